// >>> hw/triris_pkg.sv
/*
  Package for the T1 receive information/status register block.
  Holds register offsets, bit positions and timing counts.
*/
package triris_pkg;
  // Register offsets on the parallel control port
  localparam logic [7:0] ADDR_INFO3_A = 8'h10;
  localparam logic [7:0] ADDR_INFO3_B = 8'hb0;
  localparam logic [7:0] ADDR_INFO2_B = 8'hd1;
  // Field positions, info register 2
  localparam int BIT_SYNC_REGAINED   = 7;
  localparam int BIT_CARRIER_RESTORE = 5;
  localparam int BIT_BLUE_CLEARED    = 2;
  // Field positions, info register 3
  localparam int BIT_LEVEL_HI        = 7;
  localparam int BIT_LEVEL_LO        = 6;
  localparam int BIT_JA_NEAR_LIMIT   = 5;
  localparam int BIT_RX_CLOCK_LOST   = 4;
  localparam int BIT_LINE_CARRIER    = 3;
  localparam int BIT_AIS_CI          = 0;
  // Reset value of every register and of unassigned bits
  localparam logic [7:0] REG_RESET   = 8'h00;
  // Line carrier loss criteria, in bit times
  localparam int CARRIER_LOSS_ZEROS  = 192;
  localparam int CARRIER_WIN_BITS    = 112;
  localparam int CARRIER_MIN_ONES    = 14;
  // Blue alarm: zero count over a window
  localparam int BLUE_WINDOW_US      = 3000;
  localparam int BLUE_MAX_ZEROS      = 5;
  // Jitter buffer margin in bit positions
  localparam int JA_MARGIN_BITS      = 4;
  // Receive clock loss: nominal 3 us, tolerance 2..4 us
  localparam int CLK_LOSS_NS         = 3000;
  localparam int CLK_PERIOD_NS       = 50;
  localparam int CLK_LOSS_CYCLES     = CLK_LOSS_NS / CLK_PERIOD_NS;
  localparam int BLUE_WINDOW_CYCLES  = BLUE_WINDOW_US * 1000 / CLK_PERIOD_NS;
  // Receive level codes
  localparam logic [1:0] LEVEL_0_TO_M7P5  = 2'h0;
  localparam logic [1:0] LEVEL_M7P5_M15   = 2'h1;
  localparam logic [1:0] LEVEL_M15_M22P5  = 2'h2;
  localparam logic [1:0] LEVEL_BELOW_M22P5 = 2'h3;
endpackage : triris_pkg

// >>> hw/triris_top.sv
/*
  T1 receive information/status registers: framer B info register 2
  (read-clear events) and info register 3 of both framers.
  Assumes line bits, framer statuses and the jitter buffer fill arrive
  synchronous to clk_i with a one-cycle bit strobe; the receive clock
  inputs are already sampled into clk_i.
*/
`timescale 1ns/10ps
module triris_top
  import triris_pkg::*;
#(
  parameter int JA_DEPTH = 128,
  parameter int BLUE_WIN = triris_pkg::BLUE_WINDOW_CYCLES
)
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rd_data_o,
  input  wire logic       line_bit_valid_i,
  input  wire logic       line_bit_i,
  input  wire logic       framer_b_in_sync_i,
  input  wire logic       framer_b_carrier_loss_i,
  input  wire logic       framer_a_bit_valid_i,
  input  wire logic       framer_a_bit_i,
  input  wire logic       framer_b_bit_valid_i,
  input  wire logic       framer_b_bit_i,
  input  wire logic [1:0] rx_level_code_i,
  input  wire logic [7:0] ja_fill_i,
  input  wire logic       rx_clock_in_a,
  input  wire logic       rx_clock_in_b,
  input  wire logic       ais_ci_pattern_a_i,
  input  wire logic       ais_ci_pattern_b_i,
  output logic            blue_alarm_status_a_o,
  output logic            blue_alarm_status_b_o
);
  import triris_pkg::*;

  // Fill compare is eight bits wide, so the buffer depth must fit it
  if (JA_DEPTH < 8 || JA_DEPTH > 255 || BLUE_WIN < 1)
  begin : g_param_check
    $error("triris_top: unsupported parameter");
  end

  // ----------------------------------------------------------------
  // Blue alarm detectors, one per framer
  // ----------------------------------------------------------------
  logic [1:0]  fr_bit_valid;
  logic [1:0]  fr_bit;
  logic [1:0]  blue_reg;
  assign fr_bit_valid = {framer_b_bit_valid_i, framer_a_bit_valid_i};
  assign fr_bit       = {framer_b_bit_i, framer_a_bit_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_blue
      logic [31:0] win_cnt_reg;
      logic [2:0]  zero_cnt_reg;
      // Zeros saturate at six: only the threshold matters
      always_ff @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          win_cnt_reg  <= '0;
          zero_cnt_reg <= '0;
          blue_reg[g]  <= 1'b0;
        end
        else if (win_cnt_reg == 32'(BLUE_WIN - 1))
        begin
          win_cnt_reg  <= '0;
          zero_cnt_reg <= '0;
          // The window's last bit counts too, else a sixth zero could be missed
          blue_reg[g]  <= ((zero_cnt_reg + 3'(fr_bit_valid[g] && !fr_bit[g]))
                          <= 3'(BLUE_MAX_ZEROS));
        end
        else
        begin
          win_cnt_reg <= win_cnt_reg + 32'h1;
          if (fr_bit_valid[g] && !fr_bit[g] && zero_cnt_reg != 3'(BLUE_MAX_ZEROS + 1))
            zero_cnt_reg <= zero_cnt_reg + 3'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      blue_alarm_status_a_o <= 1'b0;
      blue_alarm_status_b_o <= 1'b0;
    end
    else
    begin
      blue_alarm_status_a_o <= blue_reg[0];
      blue_alarm_status_b_o <= blue_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // Line carrier loss (192 zeros set, 14 ones in 112 bits clear)
  // ----------------------------------------------------------------
  logic [7:0] zero_run_reg;
  logic [6:0] clr_pos_reg;
  logic [4:0] clr_ones_reg;
  logic       carrier_lost_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      zero_run_reg     <= '0;
      clr_pos_reg      <= '0;
      clr_ones_reg     <= '0;
      carrier_lost_reg <= 1'b0;
    end
    else if (line_bit_valid_i)
    begin
      zero_run_reg <= line_bit_i ? 8'h00 :
                      (zero_run_reg == 8'(CARRIER_LOSS_ZEROS) ? zero_run_reg : zero_run_reg + 8'h1);
      if (!carrier_lost_reg)
      begin
        if (!line_bit_i && zero_run_reg == 8'(CARRIER_LOSS_ZEROS - 1))
          carrier_lost_reg <= 1'b1;
        clr_pos_reg  <= '0;
        clr_ones_reg <= '0;
      end
      else if (clr_pos_reg == 7'h0 && !line_bit_i)
        clr_ones_reg <= '0; // Window opens at the first one
      else if (line_bit_i && clr_ones_reg == 5'(CARRIER_MIN_ONES - 1))
      begin
        carrier_lost_reg <= 1'b0;
        clr_pos_reg      <= '0;
        clr_ones_reg     <= '0;
      end
      else if (clr_pos_reg == 7'(CARRIER_WIN_BITS - 1))
      begin
        clr_pos_reg  <= '0;
        clr_ones_reg <= '0;
      end
      else
      begin
        clr_pos_reg  <= clr_pos_reg + 7'h1;
        clr_ones_reg <= clr_ones_reg + 5'(line_bit_i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive clock loss watchdogs
  // ----------------------------------------------------------------
  logic [1:0] rclk_in;
  logic [1:0] rclk_lost;
  assign rclk_in = {rx_clock_in_b, rx_clock_in_a};
  generate
    for (g = 0; g < 2; g++)
    begin : g_rclk
      logic       prev_reg;
      logic [7:0] idle_cnt_reg;
      always_ff @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          prev_reg     <= 1'b0;
          idle_cnt_reg <= '0;
          rclk_lost[g] <= 1'b0;
        end
        else
        begin
          prev_reg <= rclk_in[g];
          if (prev_reg != rclk_in[g])
          begin
            idle_cnt_reg <= '0;
            rclk_lost[g] <= 1'b0;
          end
          else if (idle_cnt_reg == 8'(CLK_LOSS_CYCLES - 1))
            rclk_lost[g] <= 1'b1;
          else
            idle_cnt_reg <= idle_cnt_reg + 8'h1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Framer B read-clear events
  // ----------------------------------------------------------------
  logic sync_prev_reg, carrier_prev_reg, blue_prev_reg;
  logic sync_regained_event, framer_carrier_restored_event, blue_alarm_cleared_event;
  logic rd_info2;
  assign rd_info2 = rd_i && addr_i == ADDR_INFO2_B;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sync_prev_reg                 <= 1'b0;
      carrier_prev_reg              <= 1'b0;
      blue_prev_reg                 <= 1'b0;
      sync_regained_event           <= 1'b0;
      framer_carrier_restored_event <= 1'b0;
      blue_alarm_cleared_event      <= 1'b0;
    end
    else
    begin
      sync_prev_reg    <= framer_b_in_sync_i;
      carrier_prev_reg <= framer_b_carrier_loss_i;
      blue_prev_reg    <= blue_reg[1];
      // A new event in the read cycle wins, so it is not lost
      if (framer_b_in_sync_i && !sync_prev_reg)
        sync_regained_event <= 1'b1;
      else if (rd_info2)
        sync_regained_event <= 1'b0;
      if (!framer_b_carrier_loss_i && carrier_prev_reg)
        framer_carrier_restored_event <= 1'b1;
      else if (rd_info2)
        framer_carrier_restored_event <= 1'b0;
      if (!blue_reg[1] && blue_prev_reg)
        blue_alarm_cleared_event <= 1'b1;
      else if (rd_info2)
        blue_alarm_cleared_event <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  logic [7:0] info2_b, info3_a, info3_b;
  logic       ja_near;
  logic       rx_level_code_hi, rx_level_code_lo;
  logic       ais_ci_a, ais_ci_b;
  assign ja_near          = ja_fill_i >= 8'(JA_DEPTH - JA_MARGIN_BITS);
  assign rx_level_code_hi = rx_level_code_i[1];
  assign rx_level_code_lo = rx_level_code_i[0];
  assign ais_ci_a = ais_ci_pattern_a_i && blue_reg[0];
  assign ais_ci_b = ais_ci_pattern_b_i && blue_reg[1];

  always_comb
  begin
    info2_b = REG_RESET;
    info2_b[BIT_SYNC_REGAINED]   = sync_regained_event;
    info2_b[BIT_CARRIER_RESTORE] = framer_carrier_restored_event;
    info2_b[BIT_BLUE_CLEARED]    = blue_alarm_cleared_event;
    info3_a = REG_RESET;
    info3_a[BIT_LEVEL_HI]      = rx_level_code_hi;
    info3_a[BIT_LEVEL_LO]      = rx_level_code_lo;
    info3_a[BIT_JA_NEAR_LIMIT] = ja_near;
    info3_a[BIT_RX_CLOCK_LOST] = rclk_lost[0];
    info3_a[BIT_LINE_CARRIER]  = carrier_lost_reg;
    info3_a[BIT_AIS_CI]        = ais_ci_a;
    info3_b = REG_RESET;
    info3_b[BIT_RX_CLOCK_LOST] = rclk_lost[1];
    info3_b[BIT_AIS_CI]        = ais_ci_b;
  end

  // Registered read data: answers one cycle after rd_i
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rd_data_o <= REG_RESET;
    else if (rd_i)
      unique case (addr_i)
        ADDR_INFO2_B: rd_data_o <= info2_b;
        ADDR_INFO3_A: rd_data_o <= info3_a;
        ADDR_INFO3_B: rd_data_o <= info3_b;
        default:      rd_data_o <= REG_RESET;
      endcase
  end
endmodule : triris_top

// >>> verif/triris_asserts.sv
/* Checker for the triris_top read port and event flags.
   Bound to every triris_top; sees only its ports. */
`timescale 1ns/10ps
module triris_asserts
  import triris_pkg::*;
#(
  parameter int JA_DEPTH = 128
)
(
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       framer_b_in_sync_i,
  input wire logic       framer_b_carrier_loss_i,
  input wire logic [1:0] rx_level_code_i,
  input wire logic [7:0] ja_fill_i,
  input wire logic       ais_ci_pattern_a_i,
  input wire logic       blue_alarm_status_a_o,
  input wire logic       blue_alarm_status_b_o
);
  logic rd_a;
  logic rd_b;
  logic rd_2;
  assign rd_a = rd_i && addr_i == ADDR_INFO3_A;
  assign rd_b = rd_i && addr_i == ADDR_INFO3_B;
  assign rd_2 = rd_i && addr_i == ADDR_INFO2_B;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // --------
  // Read data against its causes
  // --------
  chk_unmapped_zero:
    assert property (rd_i && !(rd_a || rd_b || rd_2) |=> rd_data_o == 8'h00)
    else $error("unmapped read nonzero");
  chk_info2_spare:
    assert property (rd_2 |=> (rd_data_o & 8'h5b) == 8'h00)
    else $error("info2 spare bits set");
  chk_info3b_spare:
    assert property (rd_b |=> (rd_data_o & 8'hee) == 8'h00)
    else $error("info3 b spare bits set");
  chk_level_code:
    assert property (rd_a && $stable(rx_level_code_i) |=> rd_data_o[7:6] == $past(rx_level_code_i))
    else $error("level code wrong");
  chk_ja_near:
    assert property (rd_a && $stable(ja_fill_i)
      |=> rd_data_o[5] == ($past(ja_fill_i) >= JA_DEPTH - JA_MARGIN_BITS))
    else $error("near limit flag wrong");
  chk_ais_qualified:
    assert property (rd_a |=> rd_data_o[0] == ($past(ais_ci_pattern_a_i) && blue_alarm_status_a_o))
    else $error("ais flag wrong");
  // Reads two cycles after the cause, so the event is surely latched
  chk_sync_event:
    assert property ($rose(framer_b_in_sync_i) ##1 !rd_i ##1 rd_2 |=> rd_data_o[7])
    else $error("sync event lost");
  chk_carrier_event:
    assert property ($fell(framer_b_carrier_loss_i) ##1 !rd_i ##1 rd_2 |=> rd_data_o[5])
    else $error("carrier event lost");
  chk_blue_event:
    assert property ($fell(blue_alarm_status_b_o) && !rd_i ##1 !rd_i ##1 rd_2 |=> rd_data_o[2])
    else $error("blue event lost");
endmodule : triris_asserts

bind triris_top triris_asserts #(.JA_DEPTH(JA_DEPTH)) u_chk (.clk_i, .sys_rst_i, .addr_i,
  .rd_i, .rd_data_o, .framer_b_in_sync_i, .framer_b_carrier_loss_i, .rx_level_code_i,
  .ja_fill_i, .ais_ci_pattern_a_i, .blue_alarm_status_a_o, .blue_alarm_status_b_o);

// >>> verif/triris_line_model.sv
/* Received line source: a bit strobe every other cycle.
   Mode 0 all ones, 1 all zeros, else random bits. */
`timescale 1ns/10ps
module triris_line_model
(
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  output logic            bit_valid_o = 1'b0,
  output logic            bit_o       = 1'b0
);
  always @(posedge clk_i)
  begin
    bit_valid_o <= ~bit_valid_o;
    // Between strobes the data keeps moving so a stale bit is never reused
    bit_o <= bit_valid_o ? ~bit_o :
      (mode_i == 2'h0) || (mode_i != 2'h1 && $urandom_range(1) == 1);
  end
endmodule : triris_line_model

// >>> verif/triris_tb.sv
/* Self-checking bench for triris_top with the line source model.
   Blue window shortened to BW cycles; rx clocks toggle each cycle while run_a/run_b are set. */
`timescale 1ns/10ps
module testbench;
  import triris_pkg::*;
  localparam int BW = 50;
  localparam int JD = 128;
  logic       clk_i       = 1'b0;
  logic       sys_rst_i   = 1'b1;
  logic [7:0] addr_i      = 8'h00;
  logic       rd_i        = 1'b0;
  logic       sync        = 1'b0;
  logic       cl          = 1'b0;
  logic [1:0] lvl         = 2'h0;
  logic [7:0] ja          = 8'h00;
  logic       ck_a        = 1'b0;
  logic       ck_b        = 1'b0;
  logic       run_a       = 1'b1;
  logic       run_b       = 1'b1;
  logic       pa          = 1'b0;
  logic       pb          = 1'b0;
  logic [1:0] mode        = 2'h2;
  logic       bv;
  logic       bt;
  logic [7:0] rd_data_o;
  logic       bl_a;
  logic       bl_b;
  int         miscompares = 0;
  int         num_checks  = 0;
  int         cyc         = 0;
  triris_line_model line_src (.clk_i, .mode_i(mode), .bit_valid_o(bv), .bit_o(bt));
  triris_top #(.JA_DEPTH(JD), .BLUE_WIN(BW)) uut (.clk_i, .sys_rst_i, .addr_i, .rd_i,
    .rd_data_o, .line_bit_valid_i(bv), .line_bit_i(bt), .framer_b_in_sync_i(sync),
    .framer_b_carrier_loss_i(cl), .framer_a_bit_valid_i(bv), .framer_a_bit_i(bt),
    .framer_b_bit_valid_i(bv), .framer_b_bit_i(bt), .rx_level_code_i(lvl), .ja_fill_i(ja),
    .rx_clock_in_a(ck_a), .rx_clock_in_b(ck_b), .ais_ci_pattern_a_i(pa),
    .ais_ci_pattern_b_i(pb), .blue_alarm_status_a_o(bl_a), .blue_alarm_status_b_o(bl_b));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    ck_a <= run_a ? ~ck_a : ck_a;
    ck_b <= run_b ? ~ck_b : ck_b;
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  // --------
  // Tasks and expectations
  // --------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdck(input logic [7:0] a, input string n, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    chk(n, e, rd_data_o);
  endtask : rdck
  function automatic logic [7:0] e3a(input logic lost, input logic car, input logic bl);
    return {lvl, (ja >= 8'(JD - JA_MARGIN_BITS)), lost, car, 2'h0, pa & bl};
  endfunction : e3a
  function automatic logic [7:0] e3b(input logic lost, input logic bl);
    return {3'h0, lost, 3'h0, pb & bl};
  endfunction : e3b
  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    void'($urandom(32'hf534));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdck(ADDR_INFO2_B, "info2", 8'h00);
    rdck(8'h00, "unmapped", 8'h00);
    // Fill steps across the near-limit boundary, then random fills
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      lvl <= i[1:0];
      ja <= i[2] ? 8'($urandom) : 8'(JD - 5 + i);
      #1 rdck(ADDR_INFO3_A, "info3 a", e3a(1'b0, 1'b0, 1'b0));
    end
    mode <= 2'h0;
    pa <= 1'b1;
    pb <= 1'b1;
    repeat (3 * BW) @(posedge clk_i);
    chk("blue b", 8'h01, {7'h0, bl_b});
    chk("blue a", 8'h01, {7'h0, bl_a});
    rdck(ADDR_INFO3_A, "ais a", e3a(1'b0, 1'b0, 1'b1));
    rdck(ADDR_INFO3_B, "ais b", e3b(1'b0, 1'b1));
    mode <= 2'h2;
    for (int i = 0; i < 400 && bl_b !== 1'b0; i++) @(posedge clk_i);
    chk("blue off", 8'h00, {6'h0, bl_a, bl_b});
    rdck(ADDR_INFO2_B, "blue cleared", 8'h04);
    rdck(ADDR_INFO2_B, "read clears", 8'h00);
    rdck(ADDR_INFO3_A, "ais no blue", e3a(1'b0, 1'b0, 1'b0));
    // Host confirms the clear by a later re-read; the wait is scaled down for the run
    repeat (20) @(posedge clk_i);
    rdck(ADDR_INFO3_A, "ais reread", e3a(1'b0, 1'b0, 1'b0));
    cl <= 1'b1;
    @(posedge clk_i);
    cl <= 1'b0;
    sync <= 1'b1;
    @(posedge clk_i);
    rdck(ADDR_INFO2_B, "sync carrier", 8'ha0);
    rdck(ADDR_INFO2_B, "events cleared", 8'h00);
    mode <= 2'h0;
    repeat (20) @(posedge clk_i);
    mode <= 2'h1;
    repeat (360) @(posedge clk_i);
    rdck(ADDR_INFO3_A, "few zeros", e3a(1'b0, 1'b0, 1'b0));
    repeat (60) @(posedge clk_i);
    rdck(ADDR_INFO3_A, "carrier lost", e3a(1'b0, 1'b1, 1'b0));
    pa <= 1'b0;
    pb <= 1'b0;
    mode <= 2'h0;
    repeat (240) @(posedge clk_i);
    rdck(ADDR_INFO3_A, "carrier back", e3a(1'b0, 1'b0, 1'b0));
    run_a <= 1'b0;
    repeat (35) @(posedge clk_i);
    rdck(ADDR_INFO3_A, "clock a short", e3a(1'b0, 1'b0, 1'b0));
    repeat (45) @(posedge clk_i);
    rdck(ADDR_INFO3_A, "clock a lost", e3a(1'b1, 1'b0, 1'b0));
    rdck(ADDR_INFO3_B, "clock b runs", e3b(1'b0, 1'b0));
    run_a <= 1'b1;
    run_b <= 1'b0;
    repeat (90) @(posedge clk_i);
    rdck(ADDR_INFO3_A, "clock a back", e3a(1'b0, 1'b0, 1'b0));
    rdck(ADDR_INFO3_B, "clock b lost", e3b(1'b1, 1'b0));
    tally_and_finish();
  end
endmodule : testbench
